// ### design/wdrc_pkg.sv
// constants for the watchdog and reset-cause block
package wdrc_pkg;
    // register byte offsets
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_WDCTRL = 8'h04;
    localparam logic [7:0] ADDR_RESTART = 8'h08;
    localparam logic [7:0] ADDR_CFG = 8'h0C;
    // reset_cause_status fields
    localparam int ST_POR = 0;
    localparam int ST_EXT = 1;
    localparam int ST_BOR = 2;
    localparam int ST_WDR = 3;
    localparam int ST_JTR = 4;
    localparam int ST_USB = 5;
    localparam int ST_FLAGS = 6;
    localparam logic [ST_FLAGS-1:0] ST_RESET = 6'h01;
    // watchdog control fields
    localparam int WC_PS0 = 0;
    localparam int WC_PS2 = 2;
    localparam int WC_RST_EN = 3;
    localparam int WC_CHG_EN = 4;
    localparam int WC_PS3 = 5;
    localparam int WC_IRQ_EN = 6;
    localparam int WC_IRQ_FLAG = 7;
    localparam int RS_RESTART = 0;
    // cfg register fields
    localparam int CF_CMP_BG = 0;
    localparam int CF_USB_CPU_RST = 1;
    // watchdog prescale: 2K oscillator cycles shifted by the select
    localparam int WDT_W = 21;
    localparam logic [WDT_W-1:0] WDT_BASE_CYC = 21'h000800;
    localparam logic [3:0] WDT_MAX_SEL = 4'h9;
    localparam logic [3:0] WDT_PS_RESET = 4'h0;
    // brownout level select
    localparam logic [2:0] BOD_LEVEL_OFF = 3'h7;
    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int CHG_WINDOW_CYC = 4;
    localparam logic [2:0] CHG_WINDOW = 3'(CHG_WINDOW_CYC);
    localparam int BOD_MIN_NS = 2000;
    localparam int BOD_MIN_CYC =
        (BOD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STARTUP_DELAY_US = 65;
    localparam int STARTUP_CYC = STARTUP_DELAY_US * 1000 / CLK_PERIOD_NS;
    localparam int STARTUP_W = 24;
    localparam int BOD_W = 12;
endpackage : wdrc_pkg

// ### design/wdrc_top.sv
// watchdog timer and reset-cause logic with an AHB-Lite register slave
//
// Implementation choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// Function
// [RULE1] watchdog reset pulse lasts one clock
// [RULE2] start-up delay begins when pulse falls
// [RULE3] brownout resets at once, releases after delay
// [RULE4] level code 111 disables brownout detector
// [RULE5] short under-voltage glitches are ignored
// [RULE6] usb bus reset resets core only
// [RULE7] status bits 7..6 read zero
// [RULE8] usb flag cleared by power-on or zero
// [RULE9] jtag flag set by jtag reset register
// [RULE10] watchdog flag set on watchdog reset
// [RULE11] brownout flag set on brownout reset
// [RULE12] external flag set on pin reset
// [RULE13] power-on flag cleared only by zero
// [RULE14] counter runs on oscillator ticks, expires
// [RULE15] restart clears counter before timeout
// [RULE16] interrupt mode raises wake-capable interrupt
// [RULE17] combined mode: interrupt then reset mode
// [RULE18] always-on fuse forces reset mode
// [RULE19] open change with change and reset enables
// [RULE20] commit within four cycles, else ignored
// [RULE21] timeout selectable from 16 ms to 8 s
// [RULE22] bandgap on for brownout, comparator or adc
// [RULE23] usb flag set by usb cpu reset
// [RULE24] writing one leaves reset flags unchanged
module wdrc_top #(
    parameter int STARTUP_CYCLES = wdrc_pkg::STARTUP_CYC
) (
    // clock, reset, enable
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // reset sources and straps
    input wire logic ext_reset_req,
    input wire logic brownout_low,
    input wire logic [2:0] brownout_level_select,
    input wire logic jtag_reset_reg,
    input wire logic usb_enabled,
    input wire logic usb_bus_reset,
    input wire logic watchdog_always_on_fuse,
    input wire logic adc_enable,
    // oscillator tick, one clock wide
    input wire logic wdt_osc_tick,
    // outputs
    output logic wdt_reset_pulse,
    output logic core_reset,
    output logic wdt_irq,
    output logic bandgap_enable
);

    // bus address phase
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rd_word;
    wire ahb_go = hsel & htrans[1] & hready;
    wire [7:0] a_addr = haddr[7:0];
    wire wr_status = wr_pend & (wr_addr == wdrc_pkg::ADDR_STATUS);
    wire wr_ctrl = wr_pend & (wr_addr == wdrc_pkg::ADDR_WDCTRL);
    wire wr_restart = wr_pend & (wr_addr == wdrc_pkg::ADDR_RESTART);
    wire wr_cfg = wr_pend & (wr_addr == wdrc_pkg::ADDR_CFG);

    // control state
    logic [wdrc_pkg::ST_FLAGS-1:0] cause;
    logic watchdog_reset_enable;
    logic watchdog_irq_enable;
    logic [3:0] psel;
    logic irq_flag;
    logic [2:0] win_cnt;
    logic cmp_bg_sel;
    logic usb_cpu_rst_en;
    logic [wdrc_pkg::WDT_W-1:0] wdt_cnt;
    logic [wdrc_pkg::BOD_W-1:0] bod_cnt;
    logic bod_trip;
    logic [wdrc_pkg::STARTUP_W-1:0] start_cnt;

    // watchdog mode decode
    wire win_active = win_cnt != 3'h0;
    // [RULE18] fuse locks modes
    wire eff_rst = watchdog_always_on_fuse | watchdog_reset_enable | cause[wdrc_pkg::ST_WDR];
    wire eff_irq = ~watchdog_always_on_fuse & watchdog_irq_enable;
    wire wdt_run = eff_rst | eff_irq;
    wire [3:0] wr_ps = {hwdata[wdrc_pkg::WC_PS3],
                        hwdata[wdrc_pkg::WC_PS2:wdrc_pkg::WC_PS0]};
    // [RULE19] opening write
    wire chg_open = wr_ctrl & hwdata[wdrc_pkg::WC_CHG_EN]
                    & hwdata[wdrc_pkg::WC_RST_EN];
    // [RULE20] commit only inside window
    wire chg_commit = wr_ctrl & win_active & ~hwdata[wdrc_pkg::WC_CHG_EN];

    // [RULE21] reserved selects clamp to the longest period
    wire [3:0] ps_eff = (psel > wdrc_pkg::WDT_MAX_SEL) ?
                        wdrc_pkg::WDT_MAX_SEL : psel;
    wire [wdrc_pkg::WDT_W-1:0] wdt_limit = wdrc_pkg::WDT_BASE_CYC << ps_eff;
    // [RULE14] expiry on oscillator tick
    wire expire = wdt_run & wdt_osc_tick
                  & (wdt_cnt == wdt_limit - 21'h000001);
    wire wd_rst_fire = expire & eff_rst & ~eff_irq;
    wire wd_irq_fire = expire & eff_irq;
    wire combined_hit = wd_irq_fire & eff_rst;

    // [RULE15] restart clears the count
    wire [wdrc_pkg::WDT_W-1:0] next_wdt_cnt =
        (wr_restart & hwdata[wdrc_pkg::RS_RESTART]) | expire | ~wdt_run ?
        '0 : (wdt_osc_tick ? wdt_cnt + 21'h000001 : wdt_cnt);

    wire next_wde = chg_commit ? hwdata[wdrc_pkg::WC_RST_EN] :
                    (wr_ctrl & hwdata[wdrc_pkg::WC_RST_EN]) | watchdog_reset_enable;
    wire [3:0] next_psel = chg_commit ? wr_ps : psel;
    // [RULE17] first expiry switches to reset-only
    wire next_watchdog_irq_enable = combined_hit ? 1'b0 :
                     wr_ctrl ? hwdata[wdrc_pkg::WC_IRQ_EN] : watchdog_irq_enable;
    wire [2:0] next_win_cnt = chg_open ? wdrc_pkg::CHG_WINDOW :
                              (win_active ? win_cnt - 3'h1 : 3'h0);
    // [RULE16] flag set wins over write-one clear
    wire next_irq_flag = (irq_flag & ~(wr_ctrl
                          & hwdata[wdrc_pkg::WC_IRQ_FLAG])) | wd_irq_fire;

    // brownout filter
    // [RULE4] level 111 disables detector
    wire bod_en = brownout_level_select != wdrc_pkg::BOD_LEVEL_OFF;
    wire bod_low = bod_en & brownout_low;
    // [RULE5] count consecutive low cycles
    wire [wdrc_pkg::BOD_W-1:0] next_bod_cnt = ~bod_low ? '0 :
        (bod_cnt == wdrc_pkg::BOD_W'(wdrc_pkg::BOD_MIN_CYC)) ?
        bod_cnt : bod_cnt + 12'h001;
    wire next_bod_trip =
        next_bod_cnt == wdrc_pkg::BOD_W'(wdrc_pkg::BOD_MIN_CYC);

    // [RULE6] usb bus reset
    wire usb_rst_cpu = usb_enabled & usb_cpu_rst_en & usb_bus_reset;

    // [RULE2] pulse reloads delay, counting starts after it falls
    // [RULE3] brownout holds reset, delay after release
    wire src_active = ext_reset_req | bod_trip | jtag_reset_reg
                      | usb_rst_cpu | wdt_reset_pulse;
    wire [wdrc_pkg::STARTUP_W-1:0] next_start_cnt = src_active ?
        wdrc_pkg::STARTUP_W'(STARTUP_CYCLES) :
        (start_cnt != '0 ? start_cnt - 24'h000001 : start_cnt);
    wire next_core_reset = src_active | (next_start_cnt != '0);

    // reset-cause flags
    // [RULE9] [RULE10] [RULE11] [RULE12] [RULE23] hardware sets
    wire [wdrc_pkg::ST_FLAGS-1:0] cause_set = {usb_rst_cpu,
        jtag_reset_reg, wdt_reset_pulse, bod_trip, ext_reset_req, 1'b0};
    // [RULE24] only zero bits clear, set wins
    wire [wdrc_pkg::ST_FLAGS-1:0] cause_keep = wr_status ?
        hwdata[wdrc_pkg::ST_FLAGS-1:0] : '1;
    wire [wdrc_pkg::ST_FLAGS-1:0] next_cause = (cause & cause_keep)
                                                | cause_set;

    // [RULE22] bandgap enable
    wire next_bandgap = bod_en | cmp_bg_sel | adc_enable;

    // read mux
    // [RULE7] reserved status bits read zero
    wire [31:0] rd_status = {26'h0, cause};
    wire [31:0] rd_ctrl = {24'h0, irq_flag, eff_irq, psel[3], win_active,
                           eff_rst, psel[2:0]};
    wire [31:0] rd_cfg = {30'h0, usb_cpu_rst_en, cmp_bg_sel};
    always_comb begin
        case (a_addr)
            wdrc_pkg::ADDR_STATUS: rd_word = rd_status;
            wdrc_pkg::ADDR_WDCTRL: rd_word = rd_ctrl;
            wdrc_pkg::ADDR_CFG: rd_word = rd_cfg;
            default: rd_word = 32'h0;
        endcase
    end

    // bus slave; zero wait states, always OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
            hrdata <= 32'h0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else if (clk_en) begin
            wr_pend <= ahb_go & hwrite;
            wr_addr <= a_addr;
            hrdata <= (ahb_go & ~hwrite) ? rd_word : 32'h0;
        end
    end

    // watchdog registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            watchdog_reset_enable <= 1'b0;
            watchdog_irq_enable <= 1'b0;
            psel <= wdrc_pkg::WDT_PS_RESET;
            irq_flag <= 1'b0;
            win_cnt <= 3'h0;
            wdt_cnt <= '0;
            wdt_reset_pulse <= 1'b0;
            wdt_irq <= 1'b0;
        end else if (clk_en) begin
            watchdog_reset_enable <= next_wde;
            watchdog_irq_enable <= next_watchdog_irq_enable;
            psel <= next_psel;
            irq_flag <= next_irq_flag;
            win_cnt <= next_win_cnt;
            wdt_cnt <= next_wdt_cnt;
            // [RULE1] single-cycle pulse
            wdt_reset_pulse <= wd_rst_fire;
            wdt_irq <= next_irq_flag;
        end
    end

    // reset sequencing and flags; hresetn is the power-on reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            // [RULE13] power-on sets its flag, clears the others
            cause <= wdrc_pkg::ST_RESET;
            bod_cnt <= '0;
            bod_trip <= 1'b0;
            start_cnt <= '0;
            core_reset <= 1'b1;
            cmp_bg_sel <= 1'b0;
            usb_cpu_rst_en <= 1'b0;
            bandgap_enable <= 1'b0;
        end else if (clk_en) begin
            // [RULE8] usb flag clears on power-on or zero write
            cause <= next_cause;
            bod_cnt <= next_bod_cnt;
            bod_trip <= next_bod_trip;
            start_cnt <= next_start_cnt;
            core_reset <= next_core_reset;
            if (wr_cfg) begin
                cmp_bg_sel <= hwdata[wdrc_pkg::CF_CMP_BG];
                usb_cpu_rst_en <= hwdata[wdrc_pkg::CF_USB_CPU_RST];
            end
            bandgap_enable <= next_bandgap;
        end
    end

    // checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    chk_pulse_width: assert property ( // [RULE1]
        clk_en && wdt_reset_pulse |=> !wdt_reset_pulse)
        else $error("watchdog reset pulse longer than one cycle");

    chk_delay_after_pulse: assert property ( // [RULE2]
        clk_en && wdt_reset_pulse ##1 clk_en |->
        core_reset && start_cnt == STARTUP_CYCLES)
        else $error("start-up delay not loaded at pulse end");

    chk_bod_holds: assert property ( // [RULE3]
        clk_en && bod_trip |=> core_reset)
        else $error("brownout did not hold core reset");

    chk_bod_disabled: assert property ( // [RULE4]
        clk_en && brownout_level_select == wdrc_pkg::BOD_LEVEL_OFF
        |=> !bod_trip)
        else $error("brownout tripped while disabled");

    chk_bod_filter: assert property ( // [RULE5]
        $rose(bod_trip) |-> bod_cnt == wdrc_pkg::BOD_MIN_CYC)
        else $error("brownout tripped before minimum width");

    chk_usb_reset: assert property ( // [RULE6]
        clk_en && usb_rst_cpu |=> core_reset && cause[wdrc_pkg::ST_USB])
        else $error("usb bus reset did not reset core or set flag");

    chk_status_reserved: assert property ( // [RULE7]
        clk_en && ahb_go && !hwrite && a_addr == wdrc_pkg::ADDR_STATUS
        |=> hrdata[7:6] == 2'b00)
        else $error("reserved status bits read nonzero");

    chk_wd_flag: assert property ( // [RULE10]
        clk_en && wdt_reset_pulse |=> cause[wdrc_pkg::ST_WDR])
        else $error("watchdog flag not set by watchdog reset");

    chk_por_flag: assert property ( // [RULE13]
        clk_en && !(wr_status && !hwdata[wdrc_pkg::ST_POR])
        && cause[wdrc_pkg::ST_POR] |=> cause[wdrc_pkg::ST_POR])
        else $error("power-on flag cleared without zero write");

    chk_restart: assert property ( // [RULE15]
        clk_en && wr_restart && hwdata[wdrc_pkg::RS_RESTART]
        |=> wdt_cnt == '0)
        else $error("restart did not clear watchdog counter");

    chk_combined: assert property ( // [RULE17]
        clk_en && combined_hit |=> !watchdog_irq_enable && wdt_irq && !wdt_reset_pulse)
        else $error("combined mode expiry mishandled");

    chk_fuse_lock: assert property ( // [RULE18]
        watchdog_always_on_fuse |-> rd_ctrl[wdrc_pkg::WC_RST_EN]
        && !rd_ctrl[wdrc_pkg::WC_IRQ_EN])
        else $error("fuse did not lock watchdog modes");

    chk_window_guard: assert property ( // [RULE20]
        clk_en && wr_ctrl && !win_active |=> $stable(psel))
        else $error("prescale changed outside change window");

    chk_window_len: assert property ( // [RULE20]
        clk_en && chg_open ##1 clk_en[*4] |=> !win_active)
        else $error("change window not closed after four cycles");

    chk_bandgap: assert property ( // [RULE22]
        clk_en |=> bandgap_enable == $past(next_bandgap))
        else $error("bandgap enable does not follow its sources");

    chk_bandgap_bod: assert property ( // [RULE22]
        clk_en && brownout_level_select != wdrc_pkg::BOD_LEVEL_OFF
        |=> bandgap_enable)
        else $error("bandgap off while brownout detector enabled");

    chk_ext_flag: assert property ( // [RULE12]
        clk_en && ext_reset_req |=> cause[wdrc_pkg::ST_EXT])
        else $error("external flag not set by pin reset");

    chk_jtag_flag: assert property ( // [RULE9]
        clk_en && jtag_reset_reg |=> cause[wdrc_pkg::ST_JTR])
        else $error("jtag flag not set by jtag reset");

    chk_bor_flag: assert property ( // [RULE11]
        clk_en && bod_trip |=> cause[wdrc_pkg::ST_BOR])
        else $error("brownout flag not set by brownout reset");

    chk_usb_clear: assert property ( // [RULE8]
        clk_en && wr_status && !hwdata[wdrc_pkg::ST_USB] && !usb_rst_cpu
        |=> !cause[wdrc_pkg::ST_USB])
        else $error("usb flag not cleared by zero write");

    chk_write_one: assert property ( // [RULE24]
        clk_en && wr_status && hwdata[wdrc_pkg::ST_WDR]
        && cause[wdrc_pkg::ST_WDR] |=> cause[wdrc_pkg::ST_WDR])
        else $error("writing one changed a reset flag");

    chk_irq_mode: assert property ( // [RULE16]
        clk_en && wd_irq_fire |=> wdt_irq && !wdt_reset_pulse)
        else $error("interrupt mode expiry mishandled");

    chk_fuse_reset: assert property ( // [RULE18]
        clk_en && watchdog_always_on_fuse && expire |=> wdt_reset_pulse)
        else $error("fuse mode expiry gave no reset pulse");

    chk_open_window: assert property ( // [RULE19]
        clk_en && chg_open |=> win_cnt == wdrc_pkg::CHG_WINDOW)
        else $error("opening write did not open change window");

    chk_commit_psel: assert property ( // [RULE20]
        clk_en && chg_commit |=> psel == $past(wr_ps))
        else $error("prescale commit inside window lost");

    chk_limit_clamp: assert property ( // [RULE21]
        wdt_limit >= wdrc_pkg::WDT_BASE_CYC)
        else $error("watchdog limit below shortest period");

    chk_expire_clear: assert property ( // [RULE14]
        clk_en && expire |=> wdt_cnt == '0)
        else $error("watchdog counter not cleared at expiry");

    cov_wd_reset: cover property (wdt_reset_pulse ##1 core_reset);
    cov_combined: cover property (combined_hit ##[1:1000] wd_rst_fire);
    cov_bod_trip: cover property ($rose(bod_trip));
    cov_prescale: cover property (chg_commit);
    cov_irq_mode: cover property (wd_irq_fire);

endmodule // wdrc_top
`default_nettype wire

// ### testbench/tb.sv
// self-checking bench for the watchdog and reset-cause block
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int SU = 20;
    localparam int LIMIT = 40000;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout, hresp, wd_pulse, core_reset, wd_irq, bandgap;
    logic [31:0] hrdata;
    // sources: ext, brownout, jtag, usb bus reset
    logic [3:0] src = 4'h0;
    logic [2:0] level = 3'h7;
    logic usb_en = 1'b0;
    logic fuse = 1'b0;
    logic ce = 1'b1;
    logic adc = 1'b0;
    logic tick = 1'b0;
    logic tick_run = 1'b0;
    int num_errors = 0;
    int comparisons = 0;
    int pulses = 0;
    int cyc = 0;

    wdrc_top #(.STARTUP_CYCLES(SU)) dut (
        .hclk(hclk), .hresetn(hresetn), .clk_en(ce), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .ext_reset_req(src[0]),
        .brownout_low(src[1]), .brownout_level_select(level),
        .jtag_reset_reg(src[2]), .usb_enabled(usb_en),
        .usb_bus_reset(src[3]), .watchdog_always_on_fuse(fuse),
        .adc_enable(adc), .wdt_osc_tick(tick), .wdt_reset_pulse(wd_pulse),
        .core_reset(core_reset), .wdt_irq(wd_irq), .bandgap_enable(bandgap)
    );

    always #5 hclk = ~hclk;
    // oscillator tick every other clock keeps timeouts short
    always @(posedge hclk) tick <= tick_run & ~tick;
    always @(posedge hclk) begin
        if (wd_pulse === 1'b1) pulses <= pulses + 1;
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            num_errors++;
            conclude();
        end
    end

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check(input string n, input logic [31:0] e,
                         input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask

    // one single transfer; read data taken at the data-phase edge
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
        check("hresp", 32'h0, {31'h0, hresp});
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd(input string n, input logic [7:0] a,
                      input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check(n, e, q);
    endtask

    // count clocks until core reset drops, expect the start-up delay
    task automatic release_delay;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (core_reset !== 1'b0 && n < 100);
        check("release delay", 32'h1, {31'h0, n >= SU && n <= SU + 2});
    endtask

    // enable low must hide a reset source completely
    task automatic t_freeze;
        @(posedge hclk);
        ce <= 1'b0;
        src <= 4'h1;
        repeat (5) @(posedge hclk);
        check("frozen core", 32'h0, {31'h0, core_reset});
        ce <= 1'b1;
        src <= 4'h0;
        rd("frozen cause", 8'h00, 32'h01);
        $display("done freeze");
    endtask

    task automatic t_regs;
        rd("status por", 8'h00, 32'h01);
        rd("unmapped", 8'h10, 32'h0);
        wr(8'h00, 32'hFF);
        rd("status ones", 8'h00, 32'h01);
        wr(8'h00, 32'h0);
        rd("status zero", 8'h00, 32'h0);
        $display("done regs");
    endtask

    task automatic t_src(input logic [3:0] m, input int hold,
                         input logic rst, input logic [31:0] f);
        @(posedge hclk);
        src <= m;
        repeat (hold) @(posedge hclk);
        check("core reset", {31'h0, rst}, {31'h0, core_reset});
        src <= 4'h0;
        if (rst) release_delay();
        rd("cause", 8'h00, f);
        wr(8'h00, 32'h0);
        rd("cause cleared", 8'h00, 32'h0);
        $display("done source %h", m);
    endtask

    task automatic t_bandgap;
        level <= 3'h7;
        wr(8'h0C, 32'h0);
        repeat (3) @(posedge hclk);
        check("bandgap off", 32'h0, {31'h0, bandgap});
        adc <= 1'b1;
        repeat (3) @(posedge hclk);
        check("bandgap adc", 32'h1, {31'h0, bandgap});
        adc <= 1'b0;
        wr(8'h0C, 32'h1);
        repeat (3) @(posedge hclk);
        check("bandgap cmp", 32'h1, {31'h0, bandgap});
        wr(8'h0C, 32'h0);
        level <= 3'h3;
        repeat (3) @(posedge hclk);
        check("bandgap brownout", 32'h1, {31'h0, bandgap});
        $display("done bandgap");
    endtask

    task automatic t_wd_reset;
        int n;
        tick_run <= 1'b1;
        wr(8'h04, 32'h08);
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (wd_pulse !== 1'b1 && n < 5000);
        check("expiry", 32'h1, {31'h0, n >= 4085 && n <= 4105});
        @(posedge hclk);
        tick_run <= 1'b0;
        check("pulse width", 32'h0, {31'h0, wd_pulse});
        check("core held", 32'h1, {31'h0, core_reset});
        release_delay();
        rd("cause wd", 8'h00, 32'h08);
        rd("wde forced", 8'h04, 32'h08);
        wr(8'h00, 32'h0);
        $display("done watchdog reset");
    endtask

    task automatic t_protect;
        wr(8'h04, 32'h0);
        repeat (5) @(posedge hclk);
        rd("unguarded", 8'h04, 32'h08);
        wr(8'h04, 32'h18);
        repeat (6) @(posedge hclk);
        wr(8'h04, 32'h01);
        repeat (5) @(posedge hclk);
        rd("late commit", 8'h04, 32'h08);
        wr(8'h04, 32'h18);
        wr(8'h04, 32'h40);
        repeat (5) @(posedge hclk);
        rd("timed commit", 8'h04, 32'h40);
        $display("done protected change");
    endtask

    task automatic t_irq;
        int n;
        tick_run <= 1'b1;
        repeat (1000) @(posedge hclk);
        wr(8'h08, 32'h1);
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (wd_irq !== 1'b1 && n < 5000);
        tick_run <= 1'b0;
        check("restart", 32'h1, {31'h0, n >= 4085 && n <= 4105});
        check("no pulse", 32'h1, pulses);
        check("no core reset", 32'h0, {31'h0, core_reset});
        rd("irq flag", 8'h04, 32'hC0);
        wr(8'h04, 32'h80);
        repeat (2) @(posedge hclk);
        check("irq cleared", 32'h0, {31'h0, wd_irq});
        $display("done interrupt mode");
    endtask

    task automatic t_combined;
        int n;
        tick_run <= 1'b1;
        wr(8'h04, 32'h48);
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (wd_irq !== 1'b1 && n < 5000);
        check("first expiry", 32'h1, {31'h0, n >= 4085 && n <= 4105});
        check("irq no pulse", 32'h1, pulses);
        rd("reset only", 8'h04, 32'h88);
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (wd_pulse !== 1'b1 && n < 5000);
        tick_run <= 1'b0;
        check("second expiry", 32'h1, {31'h0, n >= 4070 && n <= 4105});
        release_delay();
        check("combined pulse", 32'h2, pulses);
        rd("cause combined", 8'h00, 32'h08);
        wr(8'h00, 32'h0);
        wr(8'h04, 32'h88);
        $display("done combined mode");
    endtask

    task automatic t_fuse;
        fuse <= 1'b1;
        wr(8'h04, 32'h40);
        rd("fuse lock", 8'h04, 32'h08);
        $display("done fuse");
    endtask

    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        t_freeze();
        t_regs();
        t_src(4'h1, 5, 1'b1, 32'h02);
        t_src(4'h4, 5, 1'b1, 32'h10);
        usb_en <= 1'b1;
        wr(8'h0C, 32'h2);
        t_src(4'h8, 5, 1'b1, 32'h20);
        wr(8'h0C, 32'h0);
        t_src(4'h8, 5, 1'b0, 32'h0);
        t_src(4'h2, 300, 1'b0, 32'h0);
        level <= 3'h0;
        t_src(4'h2, 150, 1'b0, 32'h0);
        t_src(4'h2, 250, 1'b1, 32'h04);
        t_bandgap();
        t_wd_reset();
        t_protect();
        t_irq();
        t_combined();
        t_fuse();
        conclude();
    end
endmodule // tb
`default_nettype wire
